//--- rtl/slw_pkg.sv
package slw_pkg;

  // ==========================================================================
  // Geometry
  localparam int NUM_FP = 8;              // Frontplane pins in this core
  localparam int NUM_BP = 4;              // Backplane outputs
  localparam int ADJ_W  = 6;              // Clock adjust divisor width
  localparam int LCLK_W = 3;              // Base clock divider width
  localparam int PRE_W  = 4;              // Prescale-by-sixteen counter width
  localparam int BASE_W = 11;             // Base divider counter width
  localparam int BASE_SHIFT = 4;          // Sixteen = 1 << 4

  // ==========================================================================
  // Duty select codes
  localparam logic [1:0] DUTY_RSVD = 2'h0;
  localparam logic [1:0] DUTY_HALF = 2'h1;
  localparam logic [1:0] DUTY_THIRD = 2'h2;
  localparam logic [1:0] DUTY_QUART = 2'h3;

  // Clock source select codes
  localparam logic SRC_CRYSTAL = 1'b0;
  localparam logic SRC_ICG     = 1'b1;

  // ==========================================================================
  // One-third bias drive levels: 0, 1/3, 2/3, full
  localparam logic [1:0] LVL_V0 = 2'h0;
  localparam logic [1:0] LVL_V1 = 2'h1;
  localparam logic [1:0] LVL_V2 = 2'h2;
  localparam logic [1:0] LVL_V3 = 2'h3;

  // Configuration bundle
  typedef struct packed {
    logic              lcd_enable;
    logic              segment_memory_bank_select;
    logic [1:0]        duty_select;
    logic              clock_source_select;
    logic              prescale_by_sixteen;
    logic [ADJ_W-1:0]  clock_adjust_divisor;
    logic [LCLK_W-1:0] base_clock_divider;
  } slw_cfg_s;

  typedef logic [NUM_FP-1:0][NUM_BP-1:0] slw_seg_t;

endpackage : slw_pkg

//--- rtl/slw_clkdiv.sv
`timescale 1ns/1ps
// Source select, prescaler and adjust divider producing core clock ticks
module slw_clkdiv (
  // Clock and reset
  input  wire logic                    sys_clk_in,
  input  wire logic                    resetn_in,
  // Synchronised source edge strobes
  input  wire logic                    xtal_tick_in,
  input  wire logic                    icg_tick_in,
  // Configuration
  input  wire logic                    source_select_in,
  input  wire logic                    prescale_by_sixteen_in,
  input  wire logic [slw_pkg::ADJ_W-1:0] clock_adjust_divisor_in,
  // Core clock tick
  output logic                         core_tick_out
);
  import slw_pkg::*;

  logic [PRE_W-1:0] pre_cnt;
  logic [ADJ_W-1:0] adj_cnt;

  // ==========================================================================
  // Source mux and prescale
  wire src_tick = (source_select_in == SRC_ICG) ? icg_tick_in
                                                : xtal_tick_in;
  wire pre_tick = prescale_by_sixteen_in ? (src_tick && &pre_cnt)
                                         : src_tick;
  wire adj_wrap = (adj_cnt >= clock_adjust_divisor_in);

  // Counters
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_cnt       <= '0;
      adj_cnt       <= '0;
      core_tick_out <= 1'b0;
    end else begin
      if (src_tick) pre_cnt <= pre_cnt + 1'b1;
      if (pre_tick) adj_cnt <= adj_wrap ? '0 : adj_cnt + 1'b1;
      core_tick_out <= pre_tick && adj_wrap;
    end
  end

  a_core_div_rate: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    core_tick_out |-> $past(adj_wrap))
    else $error("core tick without adjust wrap");
  a_src_select: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (!prescale_by_sixteen_in && source_select_in && !icg_tick_in)
      |-> ##1 !$changed(adj_cnt))
    else $error("crystal tick leaked with internal source");

endmodule : slw_clkdiv

//--- rtl/slw_timing.sv
`timescale 1ns/1ps
module slw_timing (
  // Clock and reset
  input  wire logic                   sys_clk_in,
  input  wire logic                   resetn_in,
  // Clock sources from pins
  input  wire logic                   xtal_clk_in,
  input  wire logic                   icg_clk_in,
  // Configuration and segment memory
  input  wire slw_pkg::slw_cfg_s      cfg_in,
  input  wire logic [slw_pkg::NUM_FP-1:0] frontplane_pin_enable_in,
  input  wire slw_pkg::slw_seg_t      segment_memory_in,
  // Panel drive levels
  output logic [slw_pkg::NUM_BP-1:0][1:0] backplane_output_out,
  output logic [slw_pkg::NUM_FP-1:0][1:0] frontplane_output_out,
  output logic [slw_pkg::NUM_FP-1:0]  frontplane_active_out,
  // Status
  output logic [1:0]                  phase_out,
  output logic                        frame_start_out
);
  import slw_pkg::*;

  // ==========================================================================
  // Source synchronisers and edge detection
  logic [2:0] xtal_sync;
  logic [2:0] icg_sync;
  logic       core_tick;
  logic [BASE_W-1:0] base_cnt;
  logic [1:0] phase;
  logic       polarity;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      xtal_sync <= '0;
      icg_sync  <= '0;
    end else begin
      xtal_sync <= {xtal_sync[1:0], xtal_clk_in};
      icg_sync  <= {icg_sync[1:0], icg_clk_in};
    end
  end

  // Rising edges seen after the second stage only
  wire xtal_tick = xtal_sync[1] && !xtal_sync[2];
  wire icg_tick  = icg_sync[1] && !icg_sync[2];

  slw_clkdiv u_clkdiv (
    .sys_clk_in              (sys_clk_in),
    .resetn_in               (resetn_in),
    .xtal_tick_in            (xtal_tick),
    .icg_tick_in             (icg_tick),
    .source_select_in        (cfg_in.clock_source_select),
    .prescale_by_sixteen_in  (cfg_in.prescale_by_sixteen),
    .clock_adjust_divisor_in (cfg_in.clock_adjust_divisor),
    .core_tick_out           (core_tick)
  );

  // ==========================================================================
  // Base clock divider, phase sequencing
  function automatic logic [BASE_W-1:0] base_limit(input logic [2:0] d);
    base_limit = BASE_W'((1 << (BASE_SHIFT + d)) - 1);
  endfunction : base_limit

  function automatic logic [1:0] last_phase(input logic [1:0] duty);
    case (duty)
      DUTY_HALF:  last_phase = 2'h1;
      DUTY_THIRD: last_phase = 2'h2;
      DUTY_QUART: last_phase = 2'h3;
      default:    last_phase = 2'h0;  // Reserved: hold phase zero
    endcase
  endfunction : last_phase

  wire        base_tick = core_tick &&
                          (base_cnt >= base_limit(cfg_in.base_clock_divider));
  wire [1:0]  last_ph   = last_phase(cfg_in.duty_select);
  wire        run       = cfg_in.lcd_enable &&
                          (cfg_in.duty_select != DUTY_RSVD);
  wire        frame_end = base_tick && (phase >= last_ph);
  wire [1:0]  next_phase = frame_end ? 2'h0 : phase + 2'h1;
  // A duty cut below the current phase sends the sequence back to phase zero
  wire        ph_over   = (phase > last_ph);

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      base_cnt <= '0;
      phase    <= '0;
      polarity <= 1'b0;
    end else if (!run) begin
      base_cnt <= '0;
      phase    <= '0;
    end else if (ph_over) begin
      phase    <= '0;
    end else if (core_tick) begin
      base_cnt <= base_tick ? '0 : base_cnt + 1'b1;
      if (base_tick) phase <= next_phase;
      if (frame_end) polarity <= !polarity;          // DC-free inversion
    end
  end

  // ==========================================================================
  // One-third bias levels: selected 3/0, unselected 1/2, inverted per frame
  logic [NUM_BP-1:0][1:0] next_bp;
  logic [NUM_FP-1:0][1:0] next_fp;
  logic [NUM_FP-1:0]      next_fp_act;

  always_comb begin
    for (int b = 0; b < NUM_BP; b++) begin
      if (!run || b > int'(last_ph))
        next_bp[b] = LVL_V0;
      else if (b == int'(phase))
        next_bp[b] = polarity ? LVL_V0 : LVL_V3;
      else
        next_bp[b] = polarity ? LVL_V2 : LVL_V1;
    end
    for (int f = 0; f < NUM_FP; f++) begin
      next_fp_act[f] = run && frontplane_pin_enable_in[f];
      if (!next_fp_act[f])
        next_fp[f] = LVL_V0;
      else if (!cfg_in.segment_memory_bank_select &&
               segment_memory_in[f][phase])
        next_fp[f] = polarity ? LVL_V3 : LVL_V0;
      else
        next_fp[f] = polarity ? LVL_V1 : LVL_V2;
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      backplane_output_out  <= '0;
      frontplane_output_out <= '0;
      frontplane_active_out <= '0;
      phase_out             <= '0;
      frame_start_out       <= 1'b0;
    end else begin
      backplane_output_out  <= next_bp;
      frontplane_output_out <= next_fp;
      frontplane_active_out <= next_fp_act;
      phase_out             <= phase;
      frame_start_out       <= run && core_tick && frame_end;
    end
  end

  // ==========================================================================
  // Checks

  // A pin held off by either enable is never marked driven
  a_fp_gate_off: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    !($past(cfg_in.lcd_enable) && $past(frontplane_pin_enable_in[0]))
      |-> !frontplane_active_out[0])
    else $error("frontplane driven while disabled");

  // An undriven pin rests at the lowest level
  a_fp_idle_low: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    !next_fp_act[0]
      |=> frontplane_output_out[0] == LVL_V0)
    else $error("undriven frontplane not at lowest level");

  // An on segment sits opposite its selected backplane
  a_seg_on_level: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (next_fp_act[0] && !cfg_in.segment_memory_bank_select &&
     segment_memory_in[0][phase] && !polarity)
      |=> frontplane_output_out[0] == LVL_V0)
    else $error("on segment wrong level");

  // An off segment stays one step from the unselected level
  a_seg_off_level: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (next_fp_act[0] && !cfg_in.segment_memory_bank_select &&
     !segment_memory_in[0][phase] && !polarity)
      |=> frontplane_output_out[0] == LVL_V2)
    else $error("off segment wrong level");

  // The second bank never lights a segment
  a_bank_dark: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (next_fp_act[0] && cfg_in.segment_memory_bank_select && !polarity)
      |=> frontplane_output_out[0] == LVL_V2)
    else $error("bank one segment not dark");

  // Half duty leaves backplane 3 idle and keeps the phase at one or below
  a_duty_half_off: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    ($past(cfg_in.duty_select) == DUTY_HALF &&
     $past(cfg_in.duty_select, 2) == DUTY_HALF)
      |-> backplane_output_out[3] == LVL_V0 && phase_out <= 2'h1)
    else $error("unused backplane active in half duty");

  // Reserved duty drives nothing
  a_reserved_dark: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    cfg_in.duty_select == DUTY_RSVD
      |=> backplane_output_out == '0 && frontplane_active_out == '0)
    else $error("output active with reserved duty");

  // In a non-inverted frame the selected backplane takes the full level
  a_selected_bp: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (run && !polarity && phase <= last_ph)
      |=> backplane_output_out[$past(phase)] == LVL_V3)
    else $error("selected backplane not at full level");

  // Phase never rests beyond the last active backplane
  a_phase_range: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    run |-> phase <= last_ph || $changed(cfg_in.duty_select))
    else $error("phase beyond active backplanes");

  // A frame pulse coincides with the return to phase zero
  a_frame_pulse: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    frame_start_out
      |-> phase == 2'h0)
    else $error("frame pulse away from phase zero");

  // Each base tick inside a frame moves to the next backplane
  a_phase_step: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (run && core_tick && base_tick && !frame_end)
      |=> phase == $past(phase) + 2'h1)
    else $error("phase did not advance");

endmodule : slw_timing

//--- sim/slw_panel.sv
`timescale 1ns/1ps
// Glass model: a segment lights only under full drive across it
module slw_panel (
  // Drive from the core
  input  wire logic [slw_pkg::NUM_BP-1:0][1:0] bp_in,
  input  wire logic [slw_pkg::NUM_FP-1:0][1:0] fp_in,
  input  wire logic [1:0]                      phase_in,
  input  wire logic [slw_pkg::NUM_FP-1:0]      act_in,
  // Segments lit in the current phase
  output logic [slw_pkg::NUM_FP-1:0]           lit_out
);
  import slw_pkg::*;
  // Lit when a driven pin and its backplane stand at V0 and V3 either way
  always_comb begin
    for (int f = 0; f < NUM_FP; f++) begin
      lit_out[f] = act_in[f] &&
                   ({fp_in[f], bp_in[phase_in]} inside {4'h3, 4'hc});
    end
  end
endmodule : slw_panel

//--- sim/slw_timing_test.sv
`timescale 1ns/1ps
module slw_timing_test;
  import slw_pkg::*;
  logic                   sys_clk_in = 0, resetn_in = 0, xr = 0, ir = 0;
  logic                   xtal_clk = 0, icg_clk = 0;
  slw_cfg_s               cfg = '0;
  logic [NUM_FP-1:0]      fpe = '0, act, lit;
  slw_seg_t               seg = '0;
  logic [NUM_BP-1:0][1:0] bp;
  logic [NUM_FP-1:0][1:0] fp;
  logic [1:0]             phase;
  logic                   fs;
  int                     fail_count = 0, num_checks = 0;
  // ==========
  // Clocks: system, then gated crystal and generator
  always #5 sys_clk_in = ~sys_clk_in;
  always #20 xtal_clk = ~xtal_clk & xr;
  always #30 icg_clk = ~icg_clk & ir;
  slw_timing i_slw_timing (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .xtal_clk_in(xtal_clk), .icg_clk_in(icg_clk), .cfg_in(cfg),
    .frontplane_pin_enable_in(fpe), .segment_memory_in(seg),
    .backplane_output_out(bp), .frontplane_output_out(fp),
    .frontplane_active_out(act), .phase_out(phase), .frame_start_out(fs));
  slw_panel i_slw_panel (.bp_in(bp), .fp_in(fp), .phase_in(phase),
    .act_in(act), .lit_out(lit));
  // ==========
  // Shared helpers
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic check(logic [31:0] got, logic [31:0] exp, string m);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : check
  task automatic wait_frame(output int n);
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (fs !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      fail_count++;
      test_done();
    end
  endtask : wait_frame
  task automatic next_phase();
    logic [1:0] p0;
    int n;
    p0 = phase;
    n = 0;
    while (phase === p0 && n < 20000) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n >= 20000) begin
      fail_count++;
      test_done();
    end
    repeat (3) @(posedge sys_clk_in);
  endtask : next_phase
  // Drive levels of one phase against the walk
  task automatic chk_phase(int d, int k);
    logic       pol;
    logic [1:0] e;
    logic [NUM_FP-1:0] col;
    check(phase, k, "phase order");
    pol = (bp[k] === LVL_V0);
    for (int b = 0; b < NUM_BP; b++) begin
      e = (b == k) ? (pol ? LVL_V0 : LVL_V3) :
          (b > d) ? LVL_V0 : (pol ? LVL_V2 : LVL_V1);
      check(bp[b], e, "backplane level");
    end
    for (int f = 0; f < NUM_FP; f++) begin
      col[f] = seg[f][k];
      e = seg[f][k] ? (pol ? LVL_V3 : LVL_V0) : (pol ? LVL_V1 : LVL_V2);
      check(fp[f], e, "frontplane level");
    end
    check(lit, col, "lit segments");
  endtask : chk_phase
  // ==========
  // Half, third and quarter duty codes: phase order, backplane use, frame wrap
  task automatic t_duty();
    int n;
    for (int d = 1; d <= 3; d++) begin
      cfg.duty_select <= 2'(d);
      wait_frame(n);
      wait_frame(n);
      repeat (3) @(posedge sys_clk_in);
      chk_phase(d, 0);
      for (int k = 1; k <= d; k++) begin
        next_phase();
        chk_phase(d, k);
      end
      wait_frame(n);
      check(n > 50 && n < 66, 1, "frame wrap");
    end
  endtask : t_duty
  // Source select and divider chain against frame period
  task automatic t_clock();
    int n, chg, ex[4];
    logic [10:0] tb[4];
    logic [1:0] p0;
    ex = '{128, 192, 8192, 2048};
    // Divider settings scaled down to keep frames short in simulation
    tb = '{11'h000, 11'h400, 11'h209, 11'h01a};
    cfg.duty_select <= DUTY_HALF;
    for (int i = 0; i < 4; i++) begin
      {cfg.clock_source_select, cfg.prescale_by_sixteen,
       cfg.clock_adjust_divisor, cfg.base_clock_divider} <= tb[i];
      xr <= ~tb[i][10];
      ir <= tb[i][10];
      repeat (3) wait_frame(n);
      check(n > ex[i] - 4 && n < ex[i] + 4, 1, "period");
    end
    cfg.clock_source_select <= SRC_ICG;
    cfg.base_clock_divider <= 3'h0;
    cfg.clock_adjust_divisor <= 6'h00;
    {xr, ir} <= 2'b10;
    repeat (10) @(posedge sys_clk_in);
    p0 = phase;
    chg = 0;
    repeat (400) begin
      @(posedge sys_clk_in);
      chg += int'(phase !== p0);
    end
    check(chg, 0, "idle source stalls");
    {xr, ir} <= 2'b01;
  endtask : t_clock
  // Pin enables, global enable, reserved duty, bank select
  task automatic t_gate();
    int n;
    fpe <= 8'ha5;
    cfg.duty_select <= DUTY_QUART;
    wait_frame(n);
    repeat (3) @(posedge sys_clk_in);
    check(act, 8'ha5, "pin enables");
    cfg.segment_memory_bank_select <= 1'b1;
    wait_frame(n);
    repeat (3) @(posedge sys_clk_in);
    check(lit, 8'h00, "bank one dark");
    cfg.lcd_enable <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    check({act, bp}, 16'h0000, "global off");
    cfg.lcd_enable <= 1'b1;
    cfg.duty_select <= DUTY_RSVD;
    repeat (3) @(posedge sys_clk_in);
    check({act, bp}, 16'h0000, "reserved duty");
  endtask : t_gate
  // ==========
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    xr <= 1'b1;
    fpe <= 8'hff;
    seg <= 32'h9c63a5f1;
    cfg.duty_select <= DUTY_HALF;
    @(posedge sys_clk_in);
    cfg.lcd_enable <= 1'b1;
    t_duty();
    t_clock();
    t_gate();
    test_done();
  end
endmodule : slw_timing_test
